// *** common/wdr_pkg.sv ***
// Constants shared by the watchdog reset block
package wdr_pkg;
  // Counter chain: 12-bit prescaler below a 6-bit counter
  localparam int WDR_PRE_W = 12;
  localparam int WDR_CNT_W = 6;
  localparam int WDR_CHAIN_W = WDR_PRE_W + WDR_CNT_W;
  // Clear masks: service keeps stages 1-4, prescaler clear keeps the counter
  localparam logic [17:0] WDR_SVC_KEEP = 18'h0_000F;
  localparam logic [17:0] WDR_PRE_KEEP = 18'h3_F000;
  // Timeouts in crystal clock cycles
  localparam logic [17:0] WDR_TMO_SHORT = 18'(2**13 - 2**4);
  localparam logic [17:0] WDR_TMO_LONG = 18'(2**18 - 2**4);
  // Reset pin pulse length and power-on settle, in crystal cycles
  localparam int WDR_PULSE_CYC = 32;
  localparam logic [4:0] WDR_PULSE_LAST = 5'(WDR_PULSE_CYC - 1);
  localparam int WDR_POR_CYC = 4096;
  localparam logic [11:0] WDR_POR_LAST = 12'(WDR_POR_CYC - 1);
  // Register word indices; byte address is four times the index
  localparam logic [15:0] WDR_IDX_SERVICE = 16'hFFFF;
  localparam logic [15:0] WDR_IDX_CTRL = 16'h0000;
  localparam logic [15:0] WDR_IDX_STAT = 16'h0001;
  // Control fields
  localparam int WDR_CTRL_RATE = 0;
  localparam int WDR_CTRL_DIS = 1;
  localparam int WDR_CTRL_STOPEN = 2;
  localparam logic [2:0] WDR_CTRL_RST = 3'h0;
  // Status fields
  localparam int WDR_STAT_CAUSE = 0;
  localparam int WDR_STAT_BUSY = 1;
  localparam int WDR_STAT_STOP = 2;
  localparam int WDR_STAT_EN = 3;
  localparam int WDR_STAT_CNT = 8;
endpackage

// *** common/wdr_pulse_if.sv ***
// Link between the watchdog core and the reset pulse generator
`timescale 1ns/1ps
`default_nettype none
interface wdr_pulse_if;
  logic fire;
  logic busy;
  modport core (output fire, input busy);
  modport gen (input fire, output busy);
endinterface
`default_nettype wire

// *** verilog/wdr_rst_pulse.sv ***
// Reset pin pulse generator
`timescale 1ns/1ps
`default_nettype none
module wdr_rst_pulse
  import wdr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Core link
  wdr_pulse_if.gen p
);
  typedef enum logic {PS_IDLE, PS_LOW} wdr_pstate_t;
  typedef struct packed {
    wdr_pstate_t st;
    logic [4:0] cnt;
  } wdr_pulse_t;

  wdr_pulse_t s_r;
  wdr_pulse_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      PS_IDLE: begin
        if (p.fire) begin
          s_nxt.st = PS_LOW;
          s_nxt.cnt = '0;
        end
      end
      PS_LOW: begin
        s_nxt.cnt = s_r.cnt + 5'h1;
        if (s_r.cnt == WDR_PULSE_LAST) begin
          s_nxt.st = PS_IDLE;
        end
      end
      default: s_nxt.st = PS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '{st: PS_IDLE, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign p.busy = (s_r.st == PS_LOW);

  pulse_len_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(p.busy) |-> ##31 p.busy ##1 !p.busy)
    else $error("reset pulse not 32 cycles");
endmodule
`default_nettype wire

// *** verilog/wdr_top.sv ***
// Free-running watchdog with reset pulse and Avalon-MM registers
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module wdr_top
  import wdr_pkg::*;
#(
  parameter logic [17:0] TMO_SHORT = WDR_TMO_SHORT,
  parameter logic [17:0] TMO_LONG = WDR_TMO_LONG
) (
  // Crystal clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System events
  input wire logic internal_reset,
  input wire logic rst_vec_fetch,
  input wire logic stop_exec,
  input wire logic stop_exit,
  input wire logic [7:0] rst_vec_lo,
  // Mode pins
  input wire logic monitor_mode,
  input wire logic test_volt_hi,
  input wire logic expanded_mode,
  // Reset pin, open drain
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // System outputs
  output logic wdog_reset,
  output logic cop_enable,
  output logic ext_wr_stb,
  output logic [7:0] ext_wr_data
);
  typedef struct packed {
    logic [17:0] chain;
    logic [11:0] por_cnt;
    logic por_done;
    logic stop_mode;
    logic [2:0] ctrl;
    logic cause;
    logic ack;
    logic [31:0] rdata;
    logic ext_stb;
    logic [7:0] ext_data;
  } wdr_state_t;

  wdr_state_t s_r;
  wdr_state_t s_nxt;
  wdr_pulse_if pif ();

  logic acc;
  logic wr_ok;
  logic svc_wr;
  logic hit_svc;
  logic hit_ctrl;
  logic hit_stat;
  logic wd_on;
  logic advance;
  logic fire;
  logic [17:0] limit;

  ////////////////////////////////////////////////////////////////////
  // Decode
  assign hit_svc = (avs_address == {WDR_IDX_SERVICE, 2'b00});
  assign hit_ctrl = (avs_address == {WDR_IDX_CTRL, 2'b00});
  assign hit_stat = (avs_address == {WDR_IDX_STAT, 2'b00});
  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc & ~s_r.ack;
  assign wr_ok = avs_write & s_r.ack;
  assign svc_wr = wr_ok & hit_svc;

  ////////////////////////////////////////////////////////////////////
  // Enables
  assign cop_enable = ~(monitor_mode & test_volt_hi);
  assign wd_on = ~s_r.ctrl[WDR_CTRL_DIS] & cop_enable & s_r.por_done;
  assign advance = ~s_r.stop_mode;
  assign limit = s_r.ctrl[WDR_CTRL_RATE] ? TMO_LONG : TMO_SHORT;
  assign fire = wd_on & advance & ~pif.busy
    & (s_r.chain == limit - 18'h1);
  assign pif.fire = fire;

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = acc & ~s_r.ack;
    s_nxt.ext_stb = 1'b0;
    // Power-on settle counter
    if (!s_r.por_done) begin
      s_nxt.por_cnt = s_r.por_cnt + 12'h1;
      s_nxt.por_done = (s_r.por_cnt == WDR_POR_LAST);
    end
    // Counter chain
    if (advance) begin
      s_nxt.chain = s_r.chain + 18'h1;
    end
    if (svc_wr) begin
      s_nxt.chain = s_nxt.chain & WDR_SVC_KEEP;
    end
    if (rst_vec_fetch) begin
      s_nxt.chain = s_nxt.chain & WDR_PRE_KEEP;
    end
    if (stop_exec && s_r.ctrl[WDR_CTRL_STOPEN]) begin
      s_nxt.chain = s_nxt.chain & WDR_PRE_KEEP;
      s_nxt.stop_mode = 1'b1;
    end
    if (stop_exit) begin
      s_nxt.stop_mode = 1'b0;
    end
    if (internal_reset || fire || !wd_on) begin
      s_nxt.chain = '0;
    end
    if (internal_reset || fire) begin
      s_nxt.stop_mode = 1'b0;
    end
    // External copy of the service write
    if (svc_wr && expanded_mode) begin
      s_nxt.ext_stb = 1'b1;
      s_nxt.ext_data = avs_writedata[7:0];
    end
    // Register writes
    if (wr_ok && hit_ctrl && avs_byteenable[0]) begin
      s_nxt.ctrl = avs_writedata[2:0];
    end
    if (wr_ok && hit_stat && avs_byteenable[0]
        && avs_writedata[WDR_STAT_CAUSE]) begin
      s_nxt.cause = 1'b0;
    end
    if (fire) begin
      s_nxt.cause = 1'b1;
    end
    // Read data, captured while the request waits
    if (avs_read && !s_r.ack) begin
      s_nxt.rdata = '0;
      if (hit_svc) begin
        s_nxt.rdata[7:0] = rst_vec_lo;
      end else if (hit_ctrl) begin
        s_nxt.rdata[2:0] = s_r.ctrl;
      end else if (hit_stat) begin
        s_nxt.rdata[WDR_STAT_CAUSE] = s_r.cause;
        s_nxt.rdata[WDR_STAT_BUSY] = pif.busy;
        s_nxt.rdata[WDR_STAT_STOP] = s_r.stop_mode;
        s_nxt.rdata[WDR_STAT_EN] = cop_enable;
        s_nxt.rdata[WDR_STAT_CNT +: WDR_CNT_W] =
          s_r.chain[WDR_PRE_W +: WDR_CNT_W];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.ctrl <= WDR_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset pulse and outputs
  wdr_rst_pulse u_pulse (
    .ref_clk(ref_clk),
    .srst(srst),
    .p(pif.gen)
  );

  // Reset is the only action; no request outputs exist
  assign wdog_reset = pif.busy;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = pif.busy;
  assign avs_readdata = s_r.rdata;
  assign ext_wr_stb = s_r.ext_stb;
  assign ext_wr_data = s_r.ext_data;

  ////////////////////////////////////////////////////////////////////
  // Checks
  svc_clears_a: assert property (@(posedge ref_clk) disable iff (srst)
    svc_wr |=> s_r.chain[17:4] == '0)
    else $error("service write did not clear chain");

  cause_set_a: assert property (@(posedge ref_clk) disable iff (srst)
    fire |=> s_r.cause && rst_pin_oe [*8])
    else $error("overflow missed cause flag or pin");

  stop_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (s_r.stop_mode && $past(s_r.stop_mode)) |->
      s_r.chain <= $past(s_r.chain))
    else $error("chain advanced in stop mode");

  int_rst_a: assert property (@(posedge ref_clk) disable iff (srst)
    internal_reset |=> s_r.chain == '0)
    else $error("internal reset left chain running");

  vec_fetch_a: assert property (@(posedge ref_clk) disable iff (srst)
    rst_vec_fetch |=> s_r.chain[11:0] == '0)
    else $error("vector fetch did not clear prescaler");

  por_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !s_r.por_done |-> !fire && s_r.chain == '0)
    else $error("chain ran before power-on settle");

  read_vec_a: assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read && hit_svc && !avs_waitrequest) |->
      avs_readdata == {24'h0, $past(rst_vec_lo)} && !svc_wr)
    else $error("service read wrong or had effect");

  dis_opt_a: assert property (@(posedge ref_clk) disable iff (srst)
    s_r.ctrl[WDR_CTRL_DIS] |-> !fire)
    else $error("reset while disabled");

  mon_dis_a: assert property (@(posedge ref_clk) disable iff (srst)
    (monitor_mode && test_volt_hi) |-> !cop_enable ##1 s_r.chain == '0)
    else $error("watchdog active in monitor mode");

  stop_en_a: assert property (@(posedge ref_clk) disable iff (srst)
    (stop_exec && !s_r.ctrl[WDR_CTRL_STOPEN] && !s_r.stop_mode) |=>
      !s_r.stop_mode)
    else $error("stop taken while not enabled");

  ext_copy_a: assert property (@(posedge ref_clk) disable iff (srst)
    (svc_wr && expanded_mode) |=>
      ext_wr_stb && ext_wr_data == $past(avs_writedata[7:0]) ##1 !ext_wr_stb)
    else $error("external service copy wrong");

  stop_pre_a: assert property (@(posedge ref_clk) disable iff (srst)
    (stop_exec && s_r.ctrl[WDR_CTRL_STOPEN]) |=>
      (s_r.chain & ~WDR_PRE_KEEP) == '0)
    else $error("stop left prescaler running");

  run_count_a: assert property (@(posedge ref_clk) disable iff (srst)
    (wd_on && advance && !fire && !internal_reset && !rst_vec_fetch
      && !svc_wr && !stop_exec) |=>
      s_r.chain == $past(s_r.chain) + 18'h1)
    else $error("chain stalled outside stop mode");

  svc_keep_a: assert property (@(posedge ref_clk) disable iff (srst)
    (svc_wr && wd_on && advance && !fire && !internal_reset
      && !rst_vec_fetch && !stop_exec) |=> (s_r.chain & WDR_SVC_KEEP) ==
      (($past(s_r.chain) + 18'h1) & WDR_SVC_KEEP))
    else $error("service write cleared low prescaler stages");

  svc_once_a: assert property (@(posedge ref_clk) disable iff (srst)
    svc_wr |=> !svc_wr)
    else $error("service strobe longer than one cycle");

  one_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
    (acc && avs_waitrequest) |=> !avs_waitrequest)
    else $error("more than one wait state");

  pin_low_a: assert property (@(posedge ref_clk) disable iff (srst)
    rst_pin_oe |-> !rst_pin_o && wdog_reset)
    else $error("reset pin not driven low");

  cause_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (s_r.cause && !(wr_ok && hit_stat)) |=> s_r.cause)
    else $error("cause flag lost without clear");

  por_end_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(s_r.por_done) |-> s_r.por_cnt == '0)
    else $error("power-on settle wrong length");

  ext_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(svc_wr && expanded_mode) |=> !ext_wr_stb)
    else $error("external strobe without service write");

  en_back_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(monitor_mode && test_volt_hi) |-> cop_enable)
    else $error("enable not restored");

  stop_fire_a: assert property (@(posedge ref_clk) disable iff (srst)
    s_r.stop_mode |-> !fire)
    else $error("overflow while in stop mode");

  fire_clr_a: assert property (@(posedge ref_clk) disable iff (srst)
    fire |=> s_r.chain == '0 && pif.busy)
    else $error("overflow did not restart the chain");
endmodule
`default_nettype wire

// *** bench/wdr_cpu_model.sv ***
// CPU software model: Avalon-MM master that services the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdr_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Avalon-MM master
  output logic [17:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [3:0] avs_byteenable,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 18'h0_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0000_0000;
  end
  ////////////////////////////////////////
  // One transfer after gap idle cycles, held until waitrequest is low
  task automatic xfer(input logic wr, input logic [17:0] a,
    input logic [31:0] d, input int gap, output logic [31:0] q);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'h1;
    avs_read <= ~wr;
    avs_write <= wr;
    // Held until waitrequest is sampled low at a rising edge
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines stop showing the last value
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_wdr_top.sv ***
// Self-checking bench for the watchdog reset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_wdr_top;
  import wdr_pkg::*;
  localparam logic [17:0] A_CTRL = 18'h0_0000;
  localparam logic [17:0] A_STAT = 18'h0_0004;
  localparam logic [17:0] A_SVC = 18'h3_FFFC;
  localparam logic [17:0] A_NONE = 18'h0_0008;
  localparam int LIM_S = 64;
  localparam int LIM_L = 200;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] ev_r = 4'h0;
  logic monitor_mode = 1'b0;
  logic test_volt_hi = 1'b0;
  logic expanded_mode = 1'b0;
  logic [7:0] rst_vec_lo = 8'h5A;
  logic [17:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic rst_pin_o, rst_pin_oe, wdog_reset, cop_enable, ext_wr_stb;
  logic [7:0] ext_wr_data;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  wdr_cpu_model cpu (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  wdr_top #(.TMO_SHORT(18'h0_0040), .TMO_LONG(18'h0_00C8)) DUT (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .internal_reset(ev_r[0]), .rst_vec_fetch(ev_r[1]),
    .stop_exec(ev_r[2]), .stop_exit(ev_r[3]), .rst_vec_lo(rst_vec_lo),
    .monitor_mode(monitor_mode), .test_volt_hi(test_volt_hi),
    .expanded_mode(expanded_mode), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .wdog_reset(wdog_reset),
    .cop_enable(cop_enable), .ext_wr_stb(ext_wr_stb),
    .ext_wr_data(ext_wr_data));
  ////////////////////////////////////////
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, 0, rd);
  endtask
  task automatic rdr(input logic [17:0] a);
    cpu.xfer(1'b0, a, 32'h0000_0000, 1, rd);
  endtask
  task automatic ev(input logic [3:0] m);
    @(posedge ref_clk);
    ev_r <= m;
    @(posedge ref_clk);
    ev_r <= 4'h0;
  endtask
  task automatic no_fire(input int n);
    logic s = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      s |= wdog_reset;
    end
    `CHK("no reset", 1'b0, s)
  endtask
  // Reset within lo..hi cycles, then pulse length and cause flag
  task automatic wait_fire(input int lo, input int hi);
    int n = 0;
    int p = 0;
    while (wdog_reset !== 1'b1 && n <= hi) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("fire time", 1'b1, n >= lo && n <= hi)
    `CHK("pin data", 1'b0, rst_pin_o)
    while (rst_pin_oe === 1'b1) begin
      @(negedge ref_clk);
      p++;
    end
    `CHK("pulse len", WDR_PULSE_CYC, p)
    rdr(A_STAT);
    `CHK("cause", 1'b1, rd[WDR_STAT_CAUSE])
    wr(A_STAT, 32'h0000_0001);
    rdr(A_STAT);
    `CHK("cause clr", 1'b0, rd[WDR_STAT_CAUSE])
  endtask
  ////////////////////////////////////////
  task automatic t_por;
    no_fire(4090);
    wait_fire(55, 85);
    $display("power-on test done");
  endtask
  task automatic t_svc;
    wr(A_SVC, 32'h0000_00FF);
    @(negedge ref_clk);
    `CHK("ext off", 1'b0, ext_wr_stb)
    @(posedge ref_clk);
    expanded_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(A_SVC, 32'h0000_00A0 + i);
      @(negedge ref_clk);
      `CHK("ext stb", 1'b1, ext_wr_stb)
      `CHK("ext data", 8'hA0 + 8'(i), ext_wr_data)
      no_fire(40);
    end
    wr(A_SVC, 32'h0000_0000);
    rdr(A_SVC);
    `CHK("svc read", 32'h0000_005A, rd)
    rdr(A_NONE);
    `CHK("unmapped", 32'h0000_0000, rd)
    wait_fire(LIM_S - 28, LIM_S + 2);
    $display("service test done");
  endtask
  task automatic t_long;
    wr(A_CTRL, 32'h0000_0001);
    rdr(A_CTRL);
    `CHK("ctrl", 32'h0000_0001, rd)
    wr(A_SVC, 32'h0000_0000);
    wait_fire(LIM_L - 18, LIM_L + 2);
    wr(A_CTRL, 32'h0000_0000);
    $display("rate test done");
  endtask
  task automatic t_hold;
    wr(A_CTRL, 32'h0000_0002);
    wr(A_SVC, 32'h0000_0000);
    no_fire(300);
    wr(A_CTRL, 32'h0000_0000);
    wait_fire(LIM_S - 3, LIM_S + 3);
    @(posedge ref_clk);
    monitor_mode <= 1'b1;
    test_volt_hi <= 1'b1;
    @(negedge ref_clk);
    `CHK("cop en", 1'b0, cop_enable)
    no_fire(300);
    @(posedge ref_clk);
    test_volt_hi <= 1'b0;
    @(negedge ref_clk);
    `CHK("cop en", 1'b1, cop_enable)
    wait_fire(LIM_S - 3, LIM_S + 3);
    $display("hold test done");
  endtask
  task automatic t_stop;
    wr(A_CTRL, 32'h0000_0004);
    wr(A_SVC, 32'h0000_0000);
    ev(4'h4);
    rdr(A_STAT);
    `CHK("stop", 1'b1, rd[WDR_STAT_STOP])
    no_fire(300);
    ev(4'h8);
    wait_fire(LIM_S, LIM_S + 2);
    wr(A_CTRL, 32'h0000_0000);
    wr(A_SVC, 32'h0000_0000);
    ev(4'h4);
    rdr(A_STAT);
    `CHK("no stop", 1'b0, rd[WDR_STAT_STOP])
    wait_fire(LIM_S - 28, LIM_S + 2);
    $display("stop test done");
  endtask
  task automatic t_clr;
    for (int k = 0; k < 2; k++) begin
      wr(A_SVC, 32'h0000_0000);
      repeat (10) begin
        no_fire(30);
        ev(k ? 4'h1 : 4'h2);
      end
      wait_fire(LIM_S - 3, LIM_S + 3);
    end
    $display("clear test done");
  endtask
  ////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 15000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_por();
    t_svc();
    t_long();
    t_hold();
    t_stop();
    t_clr();
    end_sim();
  end
endmodule
`default_nettype wire
